// ==== design/rxfee_consts.svh ====
`ifndef RXFEE_CONSTS_SVH
`define RXFEE_CONSTS_SVH

// register addresses on the serial programming port
`define RXFEE_ADDR_FRONT_END 7'h00
`define RXFEE_ADDR_MOD_PF 7'h01
`define RXFEE_ADDR_SC_DIV 7'h08
`define RXFEE_ADDR_FEE_CTRL 7'h15
`define RXFEE_ADDR_FEE_RESULT 7'h16

// field positions
`define RXFEE_BIT_BYPASS 7
`define RXFEE_BIT_LOAD 0
`define RXFEE_PF_MSB 1
`define RXFEE_PF_LSB 0
`define RXFEE_SCDIV_MSB 5
`define RXFEE_SCDIV_LSB 0
`define RXFEE_MODE_MSB 1
`define RXFEE_MODE_LSB 0
`define RXFEE_LEN_MSB 3
`define RXFEE_LEN_LSB 2

// writable bit masks
`define RXFEE_MASK_MOD_PF 8'hcf
`define RXFEE_MASK_FEE_CTRL 8'h0f

// reset values
`define RXFEE_RST_FRONT_END 8'h00
`define RXFEE_RST_MOD_PF 8'h00
`define RXFEE_RST_SC_DIV 8'hc0
`define RXFEE_RST_FEE_CTRL 8'h00

// estimator
`define RXFEE_MODE_COUNT 2'h3
`define RXFEE_BASE_SYMBOLS 7'h08

// serial frame: 7 address bits, 1 direction bit, 8 data bits
`define RXFEE_HDR_LAST 4'h7
`define RXFEE_FRAME_LAST 4'hf

// filter clock phases out of the fixed divide-by-four
`define RXFEE_PHASE_A 2'h0
`define RXFEE_PHASE_B 2'h2

`endif

// ==== design/rxfee_pkg.sv ====
package rxfee_pkg;

	typedef enum logic [1:0] {
		SIO_IDLE = 2'b00,
		SIO_HEAD = 2'b01,
		SIO_DATA = 2'b11,
		SIO_DONE = 2'b10
	} rxfee_sio_state_type;

	typedef logic [7:0] rxfee_byte_type;

endpackage : rxfee_pkg

// ==== design/rxfee_buf.sv ====
`timescale 1ns/10ps
module rxfee_buf #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	logic [WIDTH-1:0] mem_q [2];
	logic [WIDTH-1:0] mem_d [2];
	logic wrIdx_q, wrIdx_d;
	logic rdIdx_q, rdIdx_d;
	logic [1:0] count_q, count_d;
	logic push, pop;

	assign inReady = (count_q != 2'h2);
	assign outValid = (count_q != 2'h0);
	assign outData = mem_q[rdIdx_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		mem_d = mem_q;
		wrIdx_d = wrIdx_q;
		rdIdx_d = rdIdx_q;
		count_d = count_q;
		if (push) begin
			mem_d[wrIdx_q] = inData;
			wrIdx_d = ~wrIdx_q;
		end
		if (pop) begin
			rdIdx_d = ~rdIdx_q;
		end
		if (push && !pop) begin
			count_d = count_q + 2'h1;
		end else if (pop && !push) begin
			count_d = count_q - 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wrIdx_q <= 1'b0;
			rdIdx_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wrIdx_q <= wrIdx_d;
			rdIdx_q <= rdIdx_d;
			count_q <= count_d;
		end
	end

endmodule : rxfee_buf

// ==== design/rxfee_top.sv ====
`timescale 1ns/10ps
`include "rxfee_consts.svh"
module rxfee_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic progEnable,
	input wire logic progClk,
	input wire logic progIoIn,
	output logic progIoOut,
	output logic progIoOe,
	input wire logic iLimit,
	input wire logic qLimit,
	input wire logic symbolTick,
	input wire logic rxDataReady,
	output logic rxDataPin,
	output logic rxDataStrobe,
	output logic frontEndBypass,
	output logic [1:0] prefilterCornerSel,
	output logic scfPhase1,
	output logic scfPhase2,
	output rxfee_pkg::rxfee_byte_type freqOffsetCount
);
	import rxfee_pkg::*;

	// serial programming port
	rxfee_sio_state_type sioState_q, sioState_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d;
	logic [6:0] addr_q, addr_d;
	logic readFrame_q, readFrame_d;
	logic progClkPrev_q;
	logic ioOut_q, ioOut_d;
	logic ioOe_q, ioOe_d;
	logic clkRise, clkFall;
	logic wrStrobe;
	logic [7:0] wrData;
	logic [7:0] rdData;

	assign clkRise = progClk && !progClkPrev_q;
	assign clkFall = !progClk && progClkPrev_q;

	always_comb begin
		sioState_d = sioState_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		addr_d = addr_q;
		readFrame_d = readFrame_q;
		ioOut_d = ioOut_q;
		ioOe_d = ioOe_q;
		wrStrobe = 1'b0;
		wrData = {shift_q[6:0], progIoIn};
		if (!progEnable) begin
			sioState_d = SIO_IDLE;
			ioOe_d = 1'b0;
			ioOut_d = 1'b0;
		end else begin
			unique case (sioState_q)
				SIO_IDLE: begin
					sioState_d = SIO_HEAD;
					bitCnt_d = 4'h0;
					readFrame_d = 1'b0;
				end
				SIO_HEAD: begin
					if (clkRise) begin
						bitCnt_d = bitCnt_q + 4'h1;
						shift_d = {shift_q[6:0], progIoIn};
						if (bitCnt_q == `RXFEE_HDR_LAST) begin
							addr_d = shift_q[6:0];
							if (progIoIn) begin
								readFrame_d = 1'b1;
								sioState_d = SIO_DONE;
								shift_d = rdData;
							end else begin
								sioState_d = SIO_DATA;
							end
						end
					end
				end
				SIO_DATA: begin
					if (clkRise) begin
						bitCnt_d = bitCnt_q + 4'h1;
						shift_d = wrData;
						if (bitCnt_q == `RXFEE_FRAME_LAST) begin
							wrStrobe = 1'b1;
							sioState_d = SIO_DONE;
						end
					end
				end
				SIO_DONE: begin
					if (readFrame_q && clkFall) begin
						ioOe_d = 1'b1;
						ioOut_d = shift_q[7];
						shift_d = {shift_q[6:0], 1'b0};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sioState_q <= SIO_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_q <= 7'h00;
			readFrame_q <= 1'b0;
			progClkPrev_q <= 1'b0;
			ioOut_q <= 1'b0;
			ioOe_q <= 1'b0;
		end else begin
			sioState_q <= sioState_d;
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			addr_q <= addr_d;
			readFrame_q <= readFrame_d;
			progClkPrev_q <= progClk;
			ioOut_q <= ioOut_d;
			ioOe_q <= ioOe_d;
		end
	end

	// configuration registers
	logic [7:0] frontEnd_q, frontEnd_d;
	logic [7:0] modPf_q, modPf_d;
	logic [7:0] scDiv_q, scDiv_d;
	logic [7:0] feeCtrl_q, feeCtrl_d;
	logic loadEvent;

	always_comb begin
		frontEnd_d = frontEnd_q;
		modPf_d = modPf_q;
		scDiv_d = scDiv_q;
		feeCtrl_d = feeCtrl_q;
		loadEvent = 1'b0;
		if (wrStrobe) begin
			unique case (addr_q)
				`RXFEE_ADDR_FRONT_END: begin
					frontEnd_d = wrData;
					loadEvent = wrData[`RXFEE_BIT_LOAD];
				end
				`RXFEE_ADDR_MOD_PF: modPf_d = wrData & `RXFEE_MASK_MOD_PF;
				`RXFEE_ADDR_SC_DIV: scDiv_d = wrData;
				`RXFEE_ADDR_FEE_CTRL: feeCtrl_d = wrData & `RXFEE_MASK_FEE_CTRL;
				default: frontEnd_d = frontEnd_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			frontEnd_q <= `RXFEE_RST_FRONT_END;
			modPf_q <= `RXFEE_RST_MOD_PF;
			scDiv_q <= `RXFEE_RST_SC_DIV;
			feeCtrl_q <= `RXFEE_RST_FEE_CTRL;
		end else begin
			frontEnd_q <= frontEnd_d;
			modPf_q <= modPf_d;
			scDiv_q <= scDiv_d;
			feeCtrl_q <= feeCtrl_d;
		end
	end

	// switched-capacitor filter clock
	logic [5:0] divCnt_q, divCnt_d;
	logic [1:0] phase_q, phase_d;
	logic [5:0] divisor;
	logic divTick;

	assign divisor = scDiv_q[`RXFEE_SCDIV_MSB:`RXFEE_SCDIV_LSB];
	assign divTick = (divisor != 6'h00) && (divCnt_q + 6'h01 >= divisor);

	always_comb begin
		divCnt_d = divTick ? 6'h00 : divCnt_q + 6'h01;
		if (divisor == 6'h00) begin
			divCnt_d = 6'h00;
		end
		phase_d = divTick ? phase_q + 2'h1 : phase_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			divCnt_q <= 6'h00;
			phase_q <= 2'h0;
		end else begin
			divCnt_q <= divCnt_d;
			phase_q <= phase_d;
		end
	end

	// demodulator decision, held until the buffer takes it
	logic iPrev_q;
	logic pendValid_q, pendValid_d;
	logic pendBit_q, pendBit_d;
	logic bufInReady, bufOutValid, bufOutData, bufPop;

	always_comb begin
		pendValid_d = pendValid_q;
		pendBit_d = pendBit_q;
		if (pendValid_q && bufInReady) begin
			pendValid_d = 1'b0;
		end
		if (iLimit && !iPrev_q && (!pendValid_q || bufInReady)) begin
			pendValid_d = 1'b1;
			pendBit_d = qLimit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			iPrev_q <= 1'b0;
			pendValid_q <= 1'b0;
			pendBit_q <= 1'b0;
		end else begin
			iPrev_q <= iLimit;
			pendValid_q <= pendValid_d;
			pendBit_q <= pendBit_d;
		end
	end

	rxfee_buf #(.WIDTH(1)) decisionBuf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inValid(pendValid_q),
		.inData(pendBit_q),
		.inReady(bufInReady),
		.outValid(bufOutValid),
		.outData(bufOutData),
		.outReady(rxDataReady)
	);

	assign bufPop = bufOutValid && rxDataReady;

	// frequency error estimator
	logic [7:0] feeCount_q, feeCount_d;
	logic [6:0] symCnt_q, symCnt_d;
	logic feeDone_q, feeDone_d;
	logic [6:0] symTarget;
	logic feeCounting;

	// read mux keyed by the address bits already in the header shift
	always_comb begin
		case (shift_q[6:0])
			`RXFEE_ADDR_FRONT_END: rdData = frontEnd_q;
			`RXFEE_ADDR_MOD_PF: rdData = modPf_q;
			`RXFEE_ADDR_SC_DIV: rdData = scDiv_q;
			`RXFEE_ADDR_FEE_CTRL: rdData = feeCtrl_q;
			`RXFEE_ADDR_FEE_RESULT: rdData = feeCount_q;
			default: rdData = 8'h00;
		endcase
	end

	assign symTarget = `RXFEE_BASE_SYMBOLS << feeCtrl_q[`RXFEE_LEN_MSB:`RXFEE_LEN_LSB];
	assign feeCounting = (feeCtrl_q[`RXFEE_MODE_MSB:`RXFEE_MODE_LSB] == `RXFEE_MODE_COUNT)
		&& !feeDone_q;

	always_comb begin
		feeCount_d = feeCount_q;
		symCnt_d = symCnt_q;
		feeDone_d = feeDone_q;
		if (loadEvent) begin
			feeCount_d = 8'h00;
			symCnt_d = 7'h00;
			feeDone_d = 1'b0;
		end else if (feeCounting) begin
			if (bufPop) begin
				// two's complement wrap kept as is
				feeCount_d = bufOutData ? feeCount_q + 8'h01 : feeCount_q - 8'h01;
			end
			if (symbolTick) begin
				symCnt_d = symCnt_q + 7'h01;
				if (symCnt_q + 7'h01 == symTarget) begin
					feeDone_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			feeCount_q <= 8'h00;
			symCnt_q <= 7'h00;
			feeDone_q <= 1'b0;
		end else begin
			feeCount_q <= feeCount_d;
			symCnt_q <= symCnt_d;
			feeDone_q <= feeDone_d;
		end
	end

	// registered pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rxDataPin <= 1'b0;
			rxDataStrobe <= 1'b0;
			frontEndBypass <= 1'b0;
			prefilterCornerSel <= 2'h0;
			scfPhase1 <= 1'b0;
			scfPhase2 <= 1'b0;
			freqOffsetCount <= 8'h00;
		end else begin
			if (bufPop) begin
				rxDataPin <= bufOutData;
			end
			rxDataStrobe <= bufPop;
			frontEndBypass <= frontEnd_q[`RXFEE_BIT_BYPASS];
			prefilterCornerSel <= modPf_q[`RXFEE_PF_MSB:`RXFEE_PF_LSB];
			scfPhase1 <= (divisor != 6'h00) && (phase_q == `RXFEE_PHASE_A);
			scfPhase2 <= (divisor != 6'h00) && (phase_q == `RXFEE_PHASE_B);
			freqOffsetCount <= feeCount_q;
		end
	end

	assign progIoOut = ioOut_q;
	assign progIoOe = ioOe_q;

endmodule : rxfee_top

// ==== test/rxfee_chk.sv ====
`timescale 1ns/10ps
module rxfee_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic progEnable,
	input wire logic progIoOe,
	input wire logic rxDataReady,
	input wire logic rxDataPin,
	input wire logic rxDataStrobe,
	input wire logic frontEndBypass,
	input wire logic [1:0] prefilterCornerSel,
	input wire logic scfPhase1,
	input wire logic scfPhase2,
	input wire rxfee_pkg::rxfee_byte_type freqOffsetCount
);
	import rxfee_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_phase_apart: assert property (!(scfPhase1 && scfPhase2))
		else $error("phases overlap");
	a_phase_gap: assert property ($fell(scfPhase1) |-> !scfPhase2)
		else $error("no gap after phase one");
	a_phase_back: assert property ($fell(scfPhase2) |-> !scfPhase1)
		else $error("no gap after phase two");
	a_pin_hold: assert property (!rxDataStrobe |-> $stable(rxDataPin))
		else $error("pin moved without strobe");
	a_pop_ready: assert property (rxDataStrobe |-> $past(rxDataReady))
		else $error("pop while not ready");
	a_count_step: assert property ($changed(freqOffsetCount) |->
		8'(freqOffsetCount - $past(freqOffsetCount)) inside {8'h01, 8'hff}
		|| freqOffsetCount == 8'h00)
		else $error("count jumped");
	a_count_cause: assert property ($changed(freqOffsetCount) &&
		freqOffsetCount != 8'h00 |-> $past(rxDataStrobe) || $past(rxDataStrobe, 2))
		else $error("count moved without pulse");
	a_cfg_quiet: assert property (!progEnable && !$past(progEnable) &&
		!$past(progEnable, 2) |-> $stable(frontEndBypass) && $stable(prefilterCornerSel))
		else $error("config changed outside frame");
	a_oe_idle: assert property (!progEnable && !$past(progEnable) &&
		!$past(progEnable, 2) |-> !progIoOe)
		else $error("data line driven outside frame");
endmodule : rxfee_chk

bind rxfee_top rxfee_chk chk_u (.clk_sys, .rst_n, .progEnable, .progIoOe, .rxDataReady,
	.rxDataPin, .rxDataStrobe, .frontEndBypass, .prefilterCornerSel, .scfPhase1,
	.scfPhase2, .freqOffsetCount);

// ==== test/rxfee_host.sv ====
`timescale 1ns/10ps
module rxfee_host (
	input wire logic clk_sys,
	input wire logic progIoLine,
	output logic progEnable,
	output logic progClk,
	output logic hostBit
);
	initial begin
		progEnable = 1'b0;
		progClk = 1'b0;
		hostBit = 1'b0;
	end
	// one frame, msb first; line toggles while released on reads
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd,
		output logic [7:0] q);
		logic [15:0] f;
		f = {a, rd, wd};
		progEnable = 1'b1;
		@(negedge clk_sys);
		for (int i = 15; i >= 0; i--) begin
			hostBit = (rd && i < 8) ? ~hostBit : f[i];
			repeat (3) @(negedge clk_sys);
			q[i % 8] = progIoLine;
			progClk = 1'b1;
			repeat (2) @(negedge clk_sys);
			progClk = 1'b0;
		end
		repeat (2) @(negedge clk_sys);
		progEnable = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : xfer
endmodule : rxfee_host

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import rxfee_pkg::*;
	logic clk_sys, rst_n, progEnable, progClk, hostBit, progIoLine, progIoOut, progIoOe;
	logic iLimit, qLimit, symbolTick, rxDataReady, rxDataPin, rxDataStrobe;
	logic frontEndBypass, scfPhase1, scfPhase2;
	logic [1:0] prefilterCornerSel;
	rxfee_byte_type freqOffsetCount;
	int mismatches = 0;
	int total_checks = 0;
	assign progIoLine = progIoOe ? progIoOut : hostBit;
	rxfee_top dut_u (.clk_sys, .rst_n, .progEnable, .progClk, .progIoIn(progIoLine),
		.progIoOut, .progIoOe, .iLimit, .qLimit, .symbolTick, .rxDataReady, .rxDataPin,
		.rxDataStrobe, .frontEndBypass, .prefilterCornerSel, .scfPhase1, .scfPhase2,
		.freqOffsetCount);
	rxfee_host host_u (.clk_sys, .progIoLine, .progEnable, .progClk, .hostBit);
	always #4 clk_sys = ~clk_sys;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s: got %h want %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic waitv(ref logic s, input logic v);
		for (int k = 0; s !== v; k++) begin
			if (k == 300) begin
				chk(8'(s), 8'(v), "timeout");
				finish_test;
			end
			@(negedge clk_sys);
		end
	endtask : waitv
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		host_u.xfer(a, 1'b0, d, x);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string msg);
		logic [7:0] x;
		host_u.xfer(a, 1'b1, 8'h00, x);
		chk(x, exp, msg);
	endtask : rd
	task automatic tone(input logic q);
		qLimit = q;
		iLimit = 1'b1;
		repeat (2) @(negedge clk_sys);
		iLimit = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask : tone
	task automatic tick(input int n);
		repeat (n) begin
			symbolTick = 1'b1;
			@(negedge clk_sys);
			symbolTick = 1'b0;
			@(negedge clk_sys);
		end
	endtask : tick
	task automatic t_reset;
		logic [6:0] a [6] = '{7'h00, 7'h01, 7'h08, 7'h15, 7'h16, 7'h7f};
		logic [7:0] e [6] = '{8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++)
			rd(a[i], e[i], "reset value");
		$display("reset done");
	endtask : t_reset
	task automatic t_config;
		wr(7'h00, 8'h80);
		chk({7'h00, frontEndBypass}, 8'h01, "bypass on");
		for (int c = 0; c < 4; c++) begin
			wr(7'h01, 8'hfc | 8'(c));
			rd(7'h01, 8'hcc | 8'(c), "prefilter reg");
			chk({6'h00, prefilterCornerSel}, 8'(c), "corner");
		end
		wr(7'h16, 8'h5a);
		rd(7'h16, 8'h00, "result read only");
		wr(7'h00, 8'h00);
		chk({7'h00, frontEndBypass}, 8'h00, "bypass off");
		$display("config done");
	endtask : t_config
	task automatic t_filter;
		int hi;
		int per;
		wr(7'h08, 8'hc3);
		waitv(scfPhase1, 1'b0);
		waitv(scfPhase1, 1'b1);
		for (hi = 0; scfPhase1 === 1'b1 && hi < 99; hi++)
			@(negedge clk_sys);
		for (per = hi; scfPhase1 !== 1'b1 && per < 99; per++)
			@(negedge clk_sys);
		chk(8'(hi), 8'h03, "phase width");
		chk(8'(per), 8'h0c, "filter period");
		repeat (6) @(negedge clk_sys);
		chk({6'h00, scfPhase1, scfPhase2}, 8'h01, "phase two");
		wr(7'h08, 8'hc0);
		chk({6'h00, scfPhase1, scfPhase2}, 8'h00, "stopped");
		$display("filter done");
	endtask : t_filter
	task automatic t_stream;
		int n = 0;
		rxDataReady = 1'b0;
		for (int i = 3; i >= 0; i--)
			tone(i[0]);
		rxDataReady = 1'b1;
		for (int i = 3; i > 0; i--) begin
			waitv(rxDataStrobe, 1'b1);
			chk({7'h00, rxDataPin}, {7'h00, i[0]}, "stream bit");
			@(negedge clk_sys);
		end
		repeat (20) begin
			n += int'(rxDataStrobe !== 1'b0);
			@(negedge clk_sys);
		end
		chk(8'(n), 8'h00, "lost edge");
		chk(freqOffsetCount, 8'h00, "count off");
		$display("stream done");
	endtask : t_stream
	task automatic t_est;
		wr(7'h15, 8'h03);
		wr(7'h00, 8'h01);
		for (int i = 0; i < 4; i++)
			tone(i != 3);
		chk(freqOffsetCount, 8'h02, "up down");
		chk(8'($signed(freqOffsetCount) > 8'sh00), 8'h01, "offset above");
		repeat (3)
			tone(1'b0);
		rd(7'h16, 8'hff, "negative result");
		wr(7'h00, 8'h01);
		chk(freqOffsetCount, 8'h00, "load clears");
		for (int c = 0; c < 4; c++) begin
			wr(7'h15, 8'(3 + 4 * c));
			wr(7'h00, 8'h01);
			tick((8 << c) - 1);
			tone(1'b1);
			tick(1);
			tone(1'b1);
			chk(freqOffsetCount, 8'h01, "symbol limit");
		end
		for (int m = 0; m < 3; m++) begin
			wr(7'h15, 8'(m));
			wr(7'h00, 8'h01);
			tone(1'b1);
			chk(freqOffsetCount, 8'h00, "mode idle");
		end
		wr(7'h15, 8'h03);
		wr(7'h00, 8'h01);
		repeat (128)
			tone(1'b1);
		rd(7'h16, 8'h80, "count wrapped");
		$display("estimator done");
	endtask : t_est
	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		iLimit = 1'b0;
		qLimit = 1'b0;
		symbolTick = 1'b0;
		rxDataReady = 1'b1;
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset;
		t_config;
		t_filter;
		t_stream;
		t_est;
		finish_test;
	end
endmodule : tb_top
